// [common/pci_pkg.sv]
// package: register map, field layout and carriers of the pin change block
package pci_pkg;

    // pin lines and groups
    localparam int unsigned PCI_PINS      = 24;
    localparam int unsigned PCI_GROUPS    = 3;
    localparam int unsigned PCI_DATA_W    = 8;
    localparam int unsigned PCI_ADDR_W    = 8;

    // pin line spans of each group
    localparam int unsigned PCI_G0_LO     = 0;
    localparam int unsigned PCI_G0_HI     = 7;
    localparam int unsigned PCI_G1_LO     = 8;
    localparam int unsigned PCI_G1_HI     = 14;
    localparam int unsigned PCI_G2_LO     = 16;
    localparam int unsigned PCI_G2_HI     = 23;

    // register offsets
    localparam logic [7:0] PCI_ADDR_GROUP_ENABLE = 8'h68;
    localparam logic [7:0] PCI_ADDR_MASK_GROUP0  = 8'h6B;
    localparam logic [7:0] PCI_ADDR_MASK_GROUP1  = 8'h6C;
    localparam logic [7:0] PCI_ADDR_MASK_GROUP2  = 8'h6D;
    localparam logic [7:0] PCI_ADDR_GROUP_FLAGS  = 8'h6E;

    // writable bits of each register; the rest read zero
    localparam logic [7:0] PCI_ENABLE_BITS = 8'h07;
    localparam logic [7:0] PCI_FLAG_BITS   = 8'h07;
    localparam logic [7:0] PCI_MASK0_BITS  = 8'hFF;
    localparam logic [7:0] PCI_MASK1_BITS  = 8'h7F;
    localparam logic [7:0] PCI_MASK2_BITS  = 8'hFF;

    // reset values
    localparam logic [7:0] PCI_RESET_BYTE  = 8'h00;
    localparam logic [2:0] PCI_RESET_GRP   = 3'h0;
    localparam logic [23:0] PCI_RESET_PINS = 24'h000000;

    // flag and enable bit positions of each group
    localparam int unsigned PCI_BIT_GROUP0 = 0;
    localparam int unsigned PCI_BIT_GROUP1 = 1;
    localparam int unsigned PCI_BIT_GROUP2 = 2;

    // register bus request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pci_bus_req_t;

    // per-group request towards the core
    typedef struct packed {
        logic group2_vector;
        logic group1_vector;
        logic group0_vector;
    } pci_vec_req_t;

endpackage

// [logic/pci_ctrl.sv]
// pin change interrupt controller: pin sync, change detect, flags, registers
//
// What this block does
// - group 2 pin change raises group 2 interrupt
// - group 1 pin change raises group 1 interrupt
// - group 0 pin change raises group 0 interrupt
// - each group requests its own vector
// - triggering change sets that group's flag bit
// - flag, enable and global enable request vector
// - vector entry clears the group's flag
// - writing one clears flag, zero keeps it
// - group 2 mask bits select pins 23..16
// - group 1 mask bits select pins 14..8
// - group 0 mask bits select pins 7..0
// - flag register bits 7..3 read zero
// - group enable register at 0x68, bits 2..0
`timescale 1ns/1ns

module pci_ctrl
    import pci_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [23:0]  pin_in,
    input  wire logic         global_irq_enable,
    input  wire logic [2:0]   vector_taken,
    input  wire pci_bus_req_t bus_req,
    output logic [7:0]        bus_rdata,
    output pci_vec_req_t      vec_req,
    output logic              irq
);

    // pin synchronizer: three stages, a level is accepted once the
    // second and third stage agree
    logic [23:0] sync1_reg;
    logic [23:0] sync2_reg;
    logic [23:0] sync3_reg;
    logic [23:0] stable_reg;
    logic [23:0] sync1_next;
    logic [23:0] sync2_next;
    logic [23:0] sync3_next;
    logic [23:0] stable_next;
    logic [23:0] pin_change;

    always_comb begin
        sync1_next  = pin_in;
        sync2_next  = sync1_reg;
        sync3_next  = sync2_reg;
        stable_next = stable_reg;
        pin_change  = 24'h000000;
        for (int i = 0; i < PCI_PINS; i++) begin
            // a change is the accepted sample differing from the last one
            if (sync2_reg[i] == sync3_reg[i]) begin
                stable_next[i] = sync3_reg[i];
                pin_change[i]  = sync3_reg[i] ^ stable_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg  <= PCI_RESET_PINS;
            sync2_reg  <= PCI_RESET_PINS;
            sync3_reg  <= PCI_RESET_PINS;
            stable_reg <= PCI_RESET_PINS;
        end else begin
            sync1_reg  <= sync1_next;
            sync2_reg  <= sync2_next;
            sync3_reg  <= sync3_next;
            stable_reg <= stable_next;
        end
    end

    // registers
    logic [7:0] group_enable_reg;
    logic [7:0] group0_mask_reg;
    logic [7:0] group1_mask_reg;
    logic [7:0] group2_mask_reg;
    logic [7:0] group_flag_reg;
    logic [7:0] group_enable_next;
    logic [7:0] group0_mask_next;
    logic [7:0] group1_mask_next;
    logic [7:0] group2_mask_next;
    logic [7:0] group_flag_next;
    logic [7:0] bus_rdata_next;
    logic [2:0] grp_set;
    logic [2:0] grp_clear;
    logic [2:0] vec_next;
    logic       irq_next;

    // change on any selected pin of an enabled group
    always_comb begin
        grp_set = 3'h0;
        grp_set[PCI_BIT_GROUP2] = group_enable_reg[PCI_BIT_GROUP2] &
            (|(pin_change[PCI_G2_HI:PCI_G2_LO] &
               group2_mask_reg[7:0]));
        grp_set[PCI_BIT_GROUP1] = group_enable_reg[PCI_BIT_GROUP1] &
            (|(pin_change[PCI_G1_HI:PCI_G1_LO] &
               group1_mask_reg[6:0]));
        grp_set[PCI_BIT_GROUP0] = group_enable_reg[PCI_BIT_GROUP0] &
            (|(pin_change[PCI_G0_HI:PCI_G0_LO] &
               group0_mask_reg[7:0]));
    end

    always_comb begin
        group_enable_next = group_enable_reg;
        group0_mask_next  = group0_mask_reg;
        group1_mask_next  = group1_mask_reg;
        group2_mask_next  = group2_mask_reg;
        grp_clear         = vector_taken;
        bus_rdata_next    = PCI_RESET_BYTE;

        if (bus_req.wr) begin
            unique case (bus_req.addr)
                PCI_ADDR_GROUP_ENABLE: begin
                    group_enable_next = bus_req.wdata & PCI_ENABLE_BITS;
                end
                PCI_ADDR_MASK_GROUP0: begin
                    group0_mask_next = bus_req.wdata & PCI_MASK0_BITS;
                end
                PCI_ADDR_MASK_GROUP1: begin
                    group1_mask_next = bus_req.wdata & PCI_MASK1_BITS;
                end
                PCI_ADDR_MASK_GROUP2: begin
                    group2_mask_next = bus_req.wdata & PCI_MASK2_BITS;
                end
                PCI_ADDR_GROUP_FLAGS: begin
                    grp_clear = grp_clear | bus_req.wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        if (bus_req.rd) begin
            unique case (bus_req.addr)
                PCI_ADDR_GROUP_ENABLE: bus_rdata_next = group_enable_reg;
                PCI_ADDR_MASK_GROUP0:  bus_rdata_next = group0_mask_reg;
                PCI_ADDR_MASK_GROUP1:  bus_rdata_next = group1_mask_reg;
                PCI_ADDR_MASK_GROUP2:  bus_rdata_next = group2_mask_reg;
                PCI_ADDR_GROUP_FLAGS:
                    bus_rdata_next = group_flag_reg & PCI_FLAG_BITS;
                default:               bus_rdata_next = PCI_RESET_BYTE;
            endcase
        end

        // a change arriving with a clear still leaves the flag set
        group_flag_next = {5'h00,
            grp_set | (group_flag_reg[2:0] & ~grp_clear)};

        // requests follow the flag just registered; a vector taken in
        // this cycle withdraws its request at once
        vec_next = group_flag_next[2:0] & group_enable_next[2:0] &
            {3{global_irq_enable}};
        irq_next = |vec_next;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            group_enable_reg <= PCI_RESET_BYTE;
            group0_mask_reg  <= PCI_RESET_BYTE;
            group1_mask_reg  <= PCI_RESET_BYTE;
            group2_mask_reg  <= PCI_RESET_BYTE;
            group_flag_reg   <= PCI_RESET_BYTE;
            bus_rdata        <= PCI_RESET_BYTE;
            vec_req          <= PCI_RESET_GRP;
            irq              <= 1'b0;
        end else begin
            group_enable_reg <= group_enable_next;
            group0_mask_reg  <= group0_mask_next;
            group1_mask_reg  <= group1_mask_next;
            group2_mask_reg  <= group2_mask_next;
            group_flag_reg   <= group_flag_next;
            bus_rdata        <= bus_rdata_next;
            vec_req          <= vec_next;
            irq              <= irq_next;
        end
    end

endmodule

// [verif/pci_ctrl_asserts.sv]
// port assertions of the pin change controller
`timescale 1ns/1ns
module pci_ctrl_asserts
    import pci_pkg::*;
(
    input wire logic         clk,
    input wire logic         arst_n,
    input wire logic [23:0]  pin_in,
    input wire logic         global_irq_enable,
    input wire logic [2:0]   vector_taken,
    input wire pci_bus_req_t bus_req,
    input wire logic [7:0]   bus_rdata,
    input wire pci_vec_req_t vec_req,
    input wire logic         irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_irq_or; irq == (vec_req != 3'h0); endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq bad");
    property p_idle; !$past(bus_req.rd) |-> bus_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("rdata bad");
    property p_flag_rsv;
        $past(bus_req.rd && bus_req.addr == 8'h6E) |-> bus_rdata[7:3] == 5'h00;
    endproperty
    a_flag_rsv: assert property (p_flag_rsv) else $error("flag bad");
    property p_en_rsv;
        $past(bus_req.rd && bus_req.addr == 8'h68) |-> bus_rdata[7:3] == 5'h00;
    endproperty
    a_en_rsv: assert property (p_en_rsv) else $error("enable bad");
    property p_m1_rsv;
        $past(bus_req.rd && bus_req.addr == 8'h6C) |-> !bus_rdata[7];
    endproperty
    a_m1_rsv: assert property (p_m1_rsv) else $error("mask bad");
    property p_gie; !global_irq_enable |=> vec_req == 3'h0; endproperty
    a_gie: assert property (p_gie) else $error("vec bad");
    property p_ack0; vector_taken[0] |=> !vec_req.group0_vector; endproperty
    a_ack0: assert property (p_ack0) else $error("ack bad");
    property p_rise; $rose(irq) |-> $past(global_irq_enable); endproperty
    a_rise: assert property (p_rise) else $error("rise bad");
    cover property ($rose(irq));
    cover property (vector_taken != 3'h0);
    cover property (bus_req.wr && bus_req.addr == 8'h6E);
endmodule
bind pci_ctrl pci_ctrl_asserts u_pci_ctrl_asserts (.clk(clk),
    .arst_n(arst_n), .pin_in(pin_in), .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .vec_req(vec_req), .irq(irq));

// [verif/pci_ctrl_tb.sv]
// testbench of the pin change controller
`timescale 1ns/1ns
module pci_ctrl_tb;
    import pci_pkg::*;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic [23:0]  pins = 24'h000000;
    logic         gie = 1'b0;
    logic         ack_en = 1'b0;
    pci_bus_req_t bus_req = '0;
    logic [7:0]   bus_rdata;
    pci_vec_req_t vec_req;
    logic         irq;
    logic [23:0]  pin_in;
    logic [2:0]   vector_taken;
    int           n_errors = 0;
    int           compares = 0;
    int           cycles = 0;
    logic [7:0]   ad [6] = '{8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6A};
    logic [7:0]   ex [6] = '{8'h07, 8'hFF, 8'h7F, 8'hFF, 8'h00, 8'h00};
    int           gp [3] = '{7, 14, 23};
    always #10 clk = ~clk;
    pci_ctrl u_pci_ctrl (.clk(clk), .arst_n(arst_n), .pin_in(pin_in),
        .global_irq_enable(gie), .vector_taken(vector_taken),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .vec_req(vec_req),
        .irq(irq));
    pci_pins_model u_pci_pins_model (.clk(clk), .arst_n(arst_n),
        .pins(pins), .ack_en(ack_en), .vec_req(vec_req),
        .pin_in(pin_in), .vector_taken(vector_taken));
    task automatic chk(input string w, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(negedge clk);
        chk("rdata", bus_rdata, e);
    endtask
    // pins pass a synchronizer, so allow several cycles before the read
    task automatic hit(input int p, input logic [7:0] f);
        @(posedge clk);
        pins[p] <= ~pins[p];
        repeat (6) @(posedge clk);
        rd(8'h6E, f);
    endtask
    task automatic wrap_up;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        foreach (ad[i]) rd(ad[i], 8'h00);
        foreach (ad[i]) wr(ad[i], 8'hFF);
        foreach (ad[i]) rd(ad[i], ex[i]);
        for (int g = 0; g < 3; g++) begin
            hit(gp[g], 8'h01 << g);
            chk("vec", {5'h00, vec_req}, 8'h00);
            @(posedge clk) gie <= 1'b1;
            repeat (2) @(negedge clk);
            chk("vec", {5'h00, vec_req}, 8'h01 << g);
            chk("irq", {7'h00, irq}, 8'h01);
            @(posedge clk) ack_en <= 1'b1;
            repeat (7) @(posedge clk);
            rd(8'h6E, 8'h00);
            @(posedge clk);
            gie <= 1'b0;
            ack_en <= 1'b0;
        end
        hit(0, 8'h01);
        wr(8'h6E, 8'hFE);
        rd(8'h6E, 8'h01);
        wr(8'h6E, 8'h01);
        rd(8'h6E, 8'h00);
        wr(8'h6B, 8'hFE);
        hit(0, 8'h00);
        hit(15, 8'h00);
        wr(8'h68, 8'h03);
        hit(16, 8'h00);
        hit(1, 8'h01);
        wr(8'h6C, 8'h3F);
        hit(14, 8'h01);
        hit(8, 8'h03);
        // a mid-run reset must bring the enable, flag and group 1 mask registers back to zero
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h68, 8'h00);
        rd(8'h6E, 8'h00);
        rd(8'h6C, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        wrap_up;
    end
endmodule

// [verif/pci_pins_model.sv]
// partner model: external pins and the core taking vectors
`timescale 1ns/1ns
module pci_pins_model
    import pci_pkg::*;
#(
    parameter int ACK_DLY = 3
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [23:0]  pins,
    input  wire logic         ack_en,
    input  wire pci_vec_req_t vec_req,
    output logic [23:0]       pin_in,
    output logic [2:0]        vector_taken
);
    logic [2:0] vr;
    int         cnt;
    assign pin_in = pins;
    assign vr = vec_req;
    // one routine at a time, lowest group first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            vector_taken <= 3'h0;
        end else if (ack_en && vr != 3'h0 && vector_taken == 3'h0) begin
            cnt <= cnt + 1;
            if (cnt == ACK_DLY) begin
                cnt <= 0;
                vector_taken <= vr & (~vr + 3'h1);
            end
        end else begin
            vector_taken <= 3'h0;
        end
    end
endmodule
